// >>> logic/scit_pkg.sv
// Package with opcode classes and timing counts for the system control and unit issue block.
`default_nettype none
package scit_pkg;
  // Instruction classes presented by the decoder.
  typedef enum logic [3:0] {
    SCIT_CLS_NONE,
    SCIT_CLS_LINE_MAINT,
    SCIT_CLS_RS_FLUSH,
    SCIT_CLS_LINE_PREF,
    SCIT_CLS_LOW_POWER,
    SCIT_CLS_WB_DRAIN,
    SCIT_CLS_UNIT_OP,
    SCIT_CLS_UNIT_LOAD,
    SCIT_CLS_UNIT_LOAD_MULTI,
    SCIT_CLS_UNIT_TO_CORE,
    SCIT_CLS_CORE_TO_UNIT,
    SCIT_CLS_UNIT_STORE,
    SCIT_CLS_UNIT_STORE_MULTI,
    SCIT_CLS_TRAP_RETURN
  } scit_class_t;
  localparam int SCIT_CNT_W = 6;
  localparam int SCIT_REG_W = 4;
  localparam int SCIT_NREGS = 16;
  localparam int SCIT_RS_DEPTH = 4;
  // Issue and result latencies in core cycles.
  localparam logic [5:0] SCIT_SYS_ISSUE = 6'h01;
  localparam logic [5:0] SCIT_SYS_RESULT = 6'h01;
  localparam logic [5:0] SCIT_OP_ISSUE = 6'h01;
  localparam logic [5:0] SCIT_LOAD_ISSUE = 6'h01;
  localparam logic [5:0] SCIT_LOAD_RESULT = 6'h05;
  localparam logic [5:0] SCIT_MVCR_ISSUE = 6'h02;
  localparam logic [5:0] SCIT_MVCR_RESULT = 6'h04;
  localparam logic [5:0] SCIT_MVRC_ISSUE = 6'h01;
  localparam logic [5:0] SCIT_MVRC_RESULT = 6'h05;
  localparam logic [5:0] SCIT_STORE_ISSUE = 6'h01;
  localparam logic [5:0] SCIT_STORE_RESULT = 6'h05;
  localparam logic [5:0] SCIT_MULTI_STORE_EXTRA = 6'h01;
  localparam logic [5:0] SCIT_TRAP_RET_ISSUE = 6'h04;
endpackage : scit_pkg
`default_nettype wire

// >>> logic/scit_scoreboard.sv
// Per-register result countdown scoreboard for the issue block.
`default_nettype none
module scit_scoreboard
  import scit_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_set,
  input wire logic [scit_pkg::SCIT_REG_W-1:0] i_set_reg,
  input wire logic [scit_pkg::SCIT_CNT_W-1:0] i_set_lat,
  output logic [scit_pkg::SCIT_NREGS-1:0] o_busy
);
  logic [SCIT_CNT_W-1:0] cnt_r [SCIT_NREGS];
  logic [SCIT_CNT_W-1:0] cnt_nxt [SCIT_NREGS];

  // Each register counts down the cycles until its result may be read.
  genvar g;
  for (g = 0; g < SCIT_NREGS; g++) begin : g_reg
    always_comb begin
      if (i_set && (i_set_reg == SCIT_REG_W'(g)) && (i_set_lat > cnt_r[g])) begin
        cnt_nxt[g] = i_set_lat - 6'h01;
      end else if (cnt_r[g] != '0) begin
        cnt_nxt[g] = cnt_r[g] - 6'h01;
      end else begin
        cnt_nxt[g] = cnt_r[g];
      end
    end
    always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
        cnt_r[g] <= '0;
      end else begin
        cnt_r[g] <= cnt_nxt[g];
      end
    end
    assign o_busy[g] = (cnt_r[g] != '0);
  end
endmodule : scit_scoreboard
`default_nettype wire

// >>> logic/scit_issue_ctrl.sv
// Issue and result-latency control for system control, unit transfer and trap return.
`default_nettype none
module scit_issue_ctrl
  import scit_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire scit_pkg::scit_class_t i_class,
  input wire logic i_dst_en,
  input wire logic [scit_pkg::SCIT_REG_W-1:0] i_dst_reg,
  input wire logic i_src_a_en,
  input wire logic [scit_pkg::SCIT_REG_W-1:0] i_src_a_reg,
  input wire logic i_src_b_en,
  input wire logic [scit_pkg::SCIT_REG_W-1:0] i_src_b_reg,
  input wire logic [scit_pkg::SCIT_CNT_W-1:0] i_multi_load_issue,
  input wire logic [scit_pkg::SCIT_CNT_W-1:0] i_multi_load_result,
  input wire logic [scit_pkg::SCIT_CNT_W-1:0] i_multi_store_issue,
  input wire logic [scit_pkg::SCIT_CNT_W-1:0] i_multi_store_result,
  output logic o_ready,
  output logic o_issued,
  output logic o_rs_flush,
  output logic o_flags_we,
  output logic o_low_power,
  output logic o_wb_drain,
  output logic o_line_maint,
  output logic o_line_pref,
  output logic o_unit_req,
  output logic [scit_pkg::SCIT_RS_DEPTH-1:0] o_rs_valid
);
  import scit_pkg::*;

  typedef enum logic [0:0] {
    SCIT_ST_IDLE,
    SCIT_ST_HOLD
  } scit_state_t;

  scit_state_t state_r, state_nxt;
  logic [SCIT_CNT_W-1:0] hold_r, hold_nxt;
  logic ready_r, ready_nxt;
  logic issued_r, issued_nxt;
  logic rs_flush_r, rs_flush_nxt;
  logic low_power_r, low_power_nxt;
  logic wb_drain_r, wb_drain_nxt;
  logic line_maint_r, line_maint_nxt;
  logic line_pref_r, line_pref_nxt;
  logic unit_req_r, unit_req_nxt;
  logic [SCIT_RS_DEPTH-1:0] rs_valid_r, rs_valid_nxt;
  logic [SCIT_NREGS-1:0] busy;
  logic hazard;
  logic take;
  logic [SCIT_CNT_W-1:0] issue_lat;
  logic [SCIT_CNT_W-1:0] result_lat;
  logic writes_core;

  // True when a class sends a request across the unit interface.
  function automatic logic scit_is_unit(input scit_class_t c);
    return (c == SCIT_CLS_UNIT_OP) || (c == SCIT_CLS_UNIT_LOAD) ||
           (c == SCIT_CLS_UNIT_LOAD_MULTI) || (c == SCIT_CLS_UNIT_TO_CORE) ||
           (c == SCIT_CLS_CORE_TO_UNIT) || (c == SCIT_CLS_UNIT_STORE) ||
           (c == SCIT_CLS_UNIT_STORE_MULTI);
  endfunction : scit_is_unit

  // Looks up the issue and result latency of the presented class.
  always_comb begin
    writes_core = 1'b0;
    result_lat = '0;
    case (i_class)
      SCIT_CLS_LINE_MAINT, SCIT_CLS_LINE_PREF, SCIT_CLS_LOW_POWER, SCIT_CLS_WB_DRAIN: begin
        issue_lat = SCIT_SYS_ISSUE;
        result_lat = SCIT_SYS_RESULT;
      end
      SCIT_CLS_RS_FLUSH: begin
        issue_lat = SCIT_SYS_ISSUE;
        result_lat = SCIT_SYS_RESULT;
      end
      SCIT_CLS_UNIT_OP: begin
        issue_lat = SCIT_OP_ISSUE;
      end
      SCIT_CLS_UNIT_LOAD: begin
        issue_lat = SCIT_LOAD_ISSUE;
        result_lat = SCIT_LOAD_RESULT;
        writes_core = 1'b1;
      end
      SCIT_CLS_UNIT_LOAD_MULTI: begin
        issue_lat = i_multi_load_issue;
        result_lat = i_multi_load_result;
        writes_core = 1'b1;
      end
      SCIT_CLS_UNIT_TO_CORE: begin
        issue_lat = SCIT_MVCR_ISSUE;
        result_lat = SCIT_MVCR_RESULT;
        writes_core = 1'b1;
      end
      SCIT_CLS_CORE_TO_UNIT: begin
        issue_lat = SCIT_MVRC_ISSUE;
        result_lat = SCIT_MVRC_RESULT;
      end
      SCIT_CLS_UNIT_STORE: begin
        issue_lat = SCIT_STORE_ISSUE;
        result_lat = SCIT_STORE_RESULT;
        writes_core = 1'b1;
      end
      SCIT_CLS_UNIT_STORE_MULTI: begin
        issue_lat = i_multi_store_issue + SCIT_MULTI_STORE_EXTRA;
        result_lat = i_multi_store_result + SCIT_MULTI_STORE_EXTRA;
        writes_core = 1'b1;
      end
      SCIT_CLS_TRAP_RETURN: begin
        issue_lat = SCIT_TRAP_RET_ISSUE;
      end
      default: begin
        issue_lat = 6'h01;
      end
    endcase
  end

  // A pending destination blocks any reader or rewriter of that register.
  assign hazard = (i_src_a_en && busy[i_src_a_reg]) || (i_src_b_en && busy[i_src_b_reg]) ||
                  (i_dst_en && busy[i_dst_reg]);
  assign take = i_valid && (i_class != SCIT_CLS_NONE) && (state_r == SCIT_ST_IDLE) && !hazard;

  // Issue state: holds the slot for the extra issue cycles of a class.
  always_comb begin
    state_nxt = state_r;
    hold_nxt = hold_r;
    case (state_r)
      SCIT_ST_IDLE: begin
        if (take && (issue_lat > 6'h01)) begin
          state_nxt = SCIT_ST_HOLD;
          hold_nxt = issue_lat - 6'h02;
        end
      end
      SCIT_ST_HOLD: begin
        if (hold_r == '0) begin
          state_nxt = SCIT_ST_IDLE;
        end else begin
          hold_nxt = hold_r - 6'h01;
        end
      end
      default: begin
        state_nxt = SCIT_ST_IDLE;
        hold_nxt = '0;
      end
    endcase
  end

  // Side effects registered for one cycle after the instruction is taken.
  always_comb begin
    issued_nxt = take;
    ready_nxt = (state_nxt == SCIT_ST_IDLE);
    rs_flush_nxt = take && (i_class == SCIT_CLS_RS_FLUSH);
    low_power_nxt = take && (i_class == SCIT_CLS_LOW_POWER);
    wb_drain_nxt = take && (i_class == SCIT_CLS_WB_DRAIN);
    line_maint_nxt = take && (i_class == SCIT_CLS_LINE_MAINT);
    line_pref_nxt = take && (i_class == SCIT_CLS_LINE_PREF);
    unit_req_nxt = take && scit_is_unit(i_class);
    rs_valid_nxt = rs_valid_r;
    if (take && (i_class == SCIT_CLS_RS_FLUSH)) begin
      rs_valid_nxt = '0;
    end
  end

  // Flags are never written by any class this block handles.
  assign o_flags_we = 1'b0;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_r <= SCIT_ST_IDLE;
      hold_r <= '0;
      ready_r <= 1'b0;
      issued_r <= 1'b0;
      rs_flush_r <= 1'b0;
      low_power_r <= 1'b0;
      wb_drain_r <= 1'b0;
      line_maint_r <= 1'b0;
      line_pref_r <= 1'b0;
      unit_req_r <= 1'b0;
      rs_valid_r <= '0;
    end else begin
      state_r <= state_nxt;
      hold_r <= hold_nxt;
      ready_r <= ready_nxt;
      issued_r <= issued_nxt;
      rs_flush_r <= rs_flush_nxt;
      low_power_r <= low_power_nxt;
      wb_drain_r <= wb_drain_nxt;
      line_maint_r <= line_maint_nxt;
      line_pref_r <= line_pref_nxt;
      unit_req_r <= unit_req_nxt;
      rs_valid_r <= rs_valid_nxt;
    end
  end

  // Destination countdowns; only classes that write a core register load them.
  scit_scoreboard u_sb (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_set(take && writes_core && i_dst_en),
    .i_set_reg(i_dst_reg),
    .i_set_lat(result_lat),
    .o_busy(busy)
  );

  assign o_ready = ready_r;
  assign o_issued = issued_r;
  assign o_rs_flush = rs_flush_r;
  assign o_low_power = low_power_r;
  assign o_wb_drain = wb_drain_r;
  assign o_line_maint = line_maint_r;
  assign o_line_pref = line_pref_r;
  assign o_unit_req = unit_req_r;
  assign o_rs_valid = rs_valid_r;
endmodule : scit_issue_ctrl
`default_nettype wire

// >>> test/scit_issue_ctrl_assertions.sv
// Checker of pulse, hold and spacing relations at the issue block ports.
`default_nettype none
module scit_issue_ctrl_assertions
  import scit_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire scit_pkg::scit_class_t i_class,
  input wire logic o_ready,
  input wire logic o_issued,
  input wire logic o_rs_flush,
  input wire logic o_flags_we,
  input wire logic o_low_power,
  input wire logic o_wb_drain,
  input wire logic o_line_maint,
  input wire logic o_line_pref,
  input wire logic o_unit_req,
  input wire logic [scit_pkg::SCIT_RS_DEPTH-1:0] o_rs_valid
);
  // All relations run on the core clock and rest during reset.
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  chk_flags_none:
    assert property (o_flags_we == 1'b0) else $error("Flag write seen.");
  chk_take_cause:
    assert property (o_issued |-> $past(i_valid) && $past(i_class) != SCIT_CLS_NONE)
    else $error("Issue without a request.");
  chk_sys_pulses:
    assert property ({o_line_maint, o_line_pref, o_low_power, o_wb_drain} == ({4{o_issued}}
      & {$past(i_class) == SCIT_CLS_LINE_MAINT, $past(i_class) == SCIT_CLS_LINE_PREF,
      $past(i_class) == SCIT_CLS_LOW_POWER, $past(i_class) == SCIT_CLS_WB_DRAIN}))
    else $error("System pulse wrong.");
  chk_flush_pulse:
    assert property (o_rs_flush == (o_issued && $past(i_class) == SCIT_CLS_RS_FLUSH))
    else $error("Flush pulse wrong.");
  chk_flush_clears:
    assert property (o_rs_flush |-> ##[0:1] o_rs_valid == 4'h0) else $error("Stack kept.");
  chk_unit_req:
    assert property (o_unit_req == (o_issued && $past(i_class) inside
      {[SCIT_CLS_UNIT_OP:SCIT_CLS_UNIT_STORE_MULTI]})) else $error("Unit request wrong.");
  chk_move_hold:
    assert property (o_issued && $past(i_class) == SCIT_CLS_UNIT_TO_CORE |-> !o_ready ##1
      !o_issued) else $error("Move issue too short.");
  chk_trap_gap:
    assert property (o_issued && $past(i_class) == SCIT_CLS_TRAP_RETURN |=> !o_issued[*3])
    else $error("Trap return issue too short.");
  chk_trap_ready:
    assert property (o_issued && $past(i_class) == SCIT_CLS_TRAP_RETURN |-> !o_ready[*3]
      ##1 o_ready) else $error("Trap return ready wrong.");
endmodule : scit_issue_ctrl_assertions
bind scit_issue_ctrl scit_issue_ctrl_assertions u_chk (.i_core_clk(i_core_clk),
  .i_rst(i_rst), .i_valid(i_valid), .i_class(i_class), .o_ready(o_ready),
  .o_issued(o_issued), .o_rs_flush(o_rs_flush), .o_flags_we(o_flags_we),
  .o_low_power(o_low_power), .o_wb_drain(o_wb_drain), .o_line_maint(o_line_maint),
  .o_line_pref(o_line_pref), .o_unit_req(o_unit_req), .o_rs_valid(o_rs_valid));
`default_nettype wire

// >>> test/scit_unit_model.sv
// Model of the attached unit, counting the requests handed to it.
`default_nettype none
module scit_unit_model (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_unit_req,
  output logic [15:0] o_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // Every request is accepted at once, so the unit never pushes back.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_count <= 16'h0000;
    end else if (i_unit_req) begin
      o_count <= o_count + 16'h0001;
    end
  end
endmodule : scit_unit_model
`default_nettype wire

// >>> test/scit_issue_ctrl_test.sv
// Bench issuing instruction pairs and checking spacing and pulses.
`default_nettype none
module scit_issue_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import scit_pkg::*;
  logic clk = 0, rst = 1, vld = 0, de = 0, sa = 0;
  scit_class_t cls = SCIT_CLS_NONE;
  logic [3:0] dr = 4'h0, sr = 4'h0, rsv;
  logic [5:0] mli = 6'h01, mlr = 6'h01, msi = 6'h01, msr = 6'h01;
  logic iss, rdy, fl, fw, lp, wb, lm, pf, ur;
  logic [15:0] ucnt;
  int error_cnt = 0, n_compared = 0, gap = 0, uexp = 0;
  logic [11:0] notes[$];
  scit_issue_ctrl u_scit_issue_ctrl (.i_core_clk(clk), .i_rst(rst), .i_valid(vld),
    .i_class(cls), .i_dst_en(de), .i_dst_reg(dr), .i_src_a_en(sa), .i_src_a_reg(sr),
    .i_src_b_en(sa), .i_src_b_reg(sr), .i_multi_load_issue(mli), .i_multi_load_result(mlr),
    .i_multi_store_issue(msi), .i_multi_store_result(msr), .o_ready(rdy), .o_issued(iss),
    .o_rs_flush(fl), .o_flags_we(fw), .o_low_power(lp), .o_wb_drain(wb), .o_line_maint(lm),
    .o_line_pref(pf), .o_unit_req(ur), .o_rs_valid(rsv));
  scit_unit_model u_scit_unit_model (.i_core_clk(clk), .i_rst(rst), .i_unit_req(ur),
    .o_count(ucnt));
  // Clock of 4 ns period.
  initial forever #2 clk = ~clk;
  // Expected pulse set of a class.
  function automatic logic [5:0] pul(scit_class_t c);
    pul = {c == SCIT_CLS_RS_FLUSH, c == SCIT_CLS_LOW_POWER, c == SCIT_CLS_WB_DRAIN,
      c == SCIT_CLS_LINE_MAINT, c == SCIT_CLS_LINE_PREF,
      c >= SCIT_CLS_UNIT_OP && c <= SCIT_CLS_UNIT_STORE_MULTI};
  endfunction : pul
  // Issue latency of a class.
  function automatic int ilat(scit_class_t c);
    case (c)
      SCIT_CLS_UNIT_TO_CORE: ilat = 2;
      SCIT_CLS_TRAP_RETURN: ilat = 4;
      SCIT_CLS_UNIT_LOAD_MULTI: ilat = int'(mli);
      SCIT_CLS_UNIT_STORE_MULTI: ilat = int'(msi) + 1;
      default: ilat = 1;
    endcase
  endfunction : ilat
  // Result latency seen by a reader of the destination.
  function automatic int rlat(scit_class_t c);
    case (c)
      SCIT_CLS_UNIT_LOAD, SCIT_CLS_UNIT_STORE: rlat = 5;
      SCIT_CLS_UNIT_TO_CORE: rlat = 4;
      SCIT_CLS_UNIT_LOAD_MULTI: rlat = int'(mlr);
      SCIT_CLS_UNIT_STORE_MULTI: rlat = int'(msr) + 1;
      default: rlat = 1;
    endcase
  endfunction : rlat
  task automatic wrap_up();
    if (error_cnt == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  // Presents one instruction, notes its expected gap (0 for any) and waits for its issue.
  task automatic send(scit_class_t c, logic [3:0] d, logic rd, logic [3:0] s, int g);
    int k;
    logic [5:0] pv;
    pv = pul(c);
    cls = c;
    de = 1'b1;
    dr = d;
    sa = rd;
    sr = s;
    vld = 1'b1;
    notes.push_back({g[5:0], pv});
    uexp += int'(pv[0]);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (iss !== 1'b1 && k < 40);
    if (iss !== 1'b1) begin
      error_cnt++;
      $display("ERROR %0t issue timed out", $time);
      wrap_up();
    end
  endtask : send
  // Compares each issue with the oldest note.
  always @(negedge clk) begin
    gap++;
    if (iss === 1'b1) begin
      n_compared++;
      if (notes.size() == 0 || {fl, lp, wb, lm, pf, ur, fw} !== {notes[0][5:0], 1'b0} ||
          (notes[0][11:6] != 6'h00 && int'(notes[0][11:6]) != gap)) begin
        error_cnt++;
        $display("ERROR %0t issue gap %0d or pulses wrong", $time, gap);
      end
      if (notes.size() > 0) void'(notes.pop_front());
      gap = 0;
    end
  end
  // Each class followed by an independent reader, then by a reader of its destination.
  initial begin
    scit_class_t c;
    logic [3:0] d;
    int il, rl;
    void'($urandom(63));
    repeat (20) @(negedge clk);
    rst = 1'b0;
    for (int p = 0; p < 26; p++) begin
      // Let every pending destination of the previous pair drain before the next pair.
      vld = 1'b0;
      repeat (10) @(negedge clk);
      c = scit_class_t'(1 + p % 13);
      d = 4'($urandom);
      mli = 6'(1 + $urandom % 4);
      mlr = 6'(1 + $urandom % 8);
      msi = 6'(1 + $urandom % 4);
      msr = 6'(1 + $urandom % 8);
      il = ilat(c);
      rl = rlat(c) > il ? rlat(c) : il;
      send(c, d, 1'b0, 4'h0, 0);
      send(SCIT_CLS_UNIT_OP, p < 13 ? d + 4'h1 : d, 1'b1, p < 13 ? d + 4'h1 : d,
        p < 13 ? il : rl);
    end
    vld = 1'b0;
    repeat (10) @(negedge clk);
    n_compared++;
    if (ucnt !== 16'(uexp)) begin
      error_cnt++;
      $display("ERROR %0t unit request count %0d", $time, ucnt);
    end
    wrap_up();
  end
endmodule : scit_issue_ctrl_test
`default_nettype wire
